/* File: design/pevis_pkg.sv */
// Purpose: shared constants and types of the phy event interrupt status block
// Assumes: management registers are reached by word index over wishbone
// Notes:   byte address of a register is four times its index
package pevis_pkg;

  //////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned PEVIS_ADR_W = 8;
  localparam int unsigned PEVIS_DAT_W = 32;
  localparam int unsigned PEVIS_REG_W = 16;
  localparam int unsigned PEVIS_IDX_W = 6;

  // register indices (byte address = index * 4)
  localparam logic [5:0] PEVIS_IDX_CTRL = 6'h11;
  localparam logic [5:0] PEVIS_IDX_LINK = 6'h12;
  localparam logic [5:0] PEVIS_IDX_LINE = 6'h13;

  //////////////////////////////////////////////////////////////////////////
  // phy_specific_control field positions
  localparam int unsigned PEVIS_CTRL_OE_POS = 0;
  localparam int unsigned PEVIS_CTRL_GIE_POS = 1;
  localparam int unsigned PEVIS_CTRL_TINT_POS = 2;
  localparam int unsigned PEVIS_CTRL_POL_POS = 3;

  // link_event_status_enable layout
  localparam int unsigned PEVIS_LINK_N = 6;
  localparam int unsigned PEVIS_LINK_STS_LSB = 8;
  localparam int unsigned PEVIS_LINK_EN_LSB = 0;

  // line_event_status_enable layout
  localparam int unsigned PEVIS_LINE_N = 7;
  localparam int unsigned PEVIS_LINE_STS_LSB = 8;
  localparam int unsigned PEVIS_LINE_EN_LSB = 0;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [5:0] PEVIS_LINK_RST = 6'h00;
  localparam logic [6:0] PEVIS_LINE_RST = 7'h00;
  localparam logic PEVIS_OE_RST = 1'b0;
  localparam logic PEVIS_GIE_RST = 1'b0;
  localparam logic PEVIS_TINT_RST = 1'b0;
  localparam logic PEVIS_POL_RST = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // event pulses, msb first in register bit order
  typedef struct packed {
    logic link_change;
    logic speed_change;
    logic duplex_change;
    logic an_complete;
    logic false_carrier_halffull;
    logic rx_error_halffull;
  } pevis_link_evt_t;

  typedef struct packed {
    logic negotiation_error;
    logic page_received;
    logic loop_fifo_overrun;
    logic crossover_change;
    logic sleep_event;
    logic polarity_change;
    logic jabber_detect;
  } pevis_line_evt_t;

  // control bits of phy_specific_control held by this block
  typedef struct packed {
    logic pol;
    logic tint;
    logic gie;
    logic oe;
  } pevis_ctrl_t;

endpackage

/* File: design/pevis_sticky.sv */
// Purpose: bank of sticky event flags with per-bit clear
// Assumes: set and clear are synchronous to ref_clk_i
// Notes:   a set in the clearing cycle wins, so no event is lost to a clear
`timescale 1ns/1ns
module pevis_sticky #(
  parameter int unsigned W = 6
) (
  input wire logic ref_clk_i,        // register clock
  input wire logic reset_i,          // sync reset, active high
  input wire logic ce_i,             // clock enable
  input wire logic [W-1:0] set_i,    // one-cycle event pulses
  input wire logic [W-1:0] clr_i,    // clear strobes from a read
  output logic [W-1:0] q_o           // latched flags
);

  //////////////////////////////////////////////////////////////////////////
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic flag_ff;
    logic nxt_flag;

    // set beats clear
    assign nxt_flag = set_i[b] | (flag_ff & ~clr_i[b]);

    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        flag_ff <= 1'b0;
      end else if (ce_i) begin
        flag_ff <= nxt_flag;
      end
    end

    assign q_o[b] = flag_ff;
  end

endmodule // pevis_sticky

/* File: design/pevis_top.sv */
// Purpose: event status latching, enables and interrupt pin control
// Assumes: event inputs are one-cycle pulses on ref_clk_i
// Notes:   classic wishbone slave, one wait state, 16-bit registers
`timescale 1ns/1ns
module pevis_top
  import pevis_pkg::*;
(
  input wire logic ref_clk_i,                   // 250 MHz register clock
  input wire logic reset_i,                     // sync reset, active high
  input wire logic ce_i,                        // freezes all state when low
  input wire logic wb_cyc_i,                    // wishbone cycle
  input wire logic wb_stb_i,                    // wishbone strobe
  input wire logic wb_we_i,                     // wishbone write
  input wire logic [PEVIS_ADR_W-1:0] wb_adr_i,  // byte address
  input wire logic [3:0] wb_sel_i,              // byte lanes
  input wire logic [PEVIS_DAT_W-1:0] wb_dat_i,  // write data
  output logic [PEVIS_DAT_W-1:0] wb_dat_o,      // read data
  output logic wb_ack_o,                        // access done
  input wire pevis_link_evt_t link_evt_i,       // link event pulses
  input wire pevis_line_evt_t line_evt_i,       // line event pulses
  input wire logic irq_pin_i,                   // shared pin level in
  output logic irq_pin_o,                       // shared pin level out
  output logic irq_pin_oe_o,                    // pin driven when high
  output logic powerdown_o,                     // powerdown request level
  output logic irq_o                            // internal irq, active high
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic ack_ff;
  logic [PEVIS_DAT_W-1:0] rdata_ff;
  logic [PEVIS_DAT_W-1:0] nxt_rdata;
  logic take;
  logic take_wr;
  logic take_rd;
  logic [PEVIS_IDX_W-1:0] idx;
  logic [PEVIS_REG_W-1:0] wdata;
  logic [PEVIS_REG_W-1:0] wmask;
  logic hit_ctrl;
  logic hit_link;
  logic hit_line;

  pevis_ctrl_t ctrl_ff;
  pevis_ctrl_t nxt_ctrl;
  logic [PEVIS_LINK_N-1:0] link_en_ff;
  logic [PEVIS_LINK_N-1:0] nxt_link_en;
  logic [PEVIS_LINE_N-1:0] line_en_ff;
  logic [PEVIS_LINE_N-1:0] nxt_line_en;

  logic [PEVIS_LINK_N-1:0] link_sts;
  logic [PEVIS_LINE_N-1:0] line_sts;
  logic [PEVIS_LINK_N-1:0] link_clr;
  logic [PEVIS_LINE_N-1:0] line_clr;

  logic pin_meta_ff;
  logic pin_sync_ff;
  logic irq_ff;
  logic irq_pin_ff;
  logic oe_pin_ff;
  logic pd_ff;
  logic event_irq;
  logic nxt_irq;

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  // a request is taken once, in the cycle before ack rises
  assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign take_wr = take & wb_we_i;
  assign take_rd = take & ~wb_we_i;
  assign idx = wb_adr_i[PEVIS_ADR_W-1:2];
  assign hit_ctrl = (idx == PEVIS_IDX_CTRL);
  assign hit_link = (idx == PEVIS_IDX_LINK);
  assign hit_line = (idx == PEVIS_IDX_LINE);
  assign wdata = wb_dat_i[PEVIS_REG_W-1:0];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  //////////////////////////////////////////////////////////////////////////
  // acknowledge: one wait state, dropped the cycle after
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= take;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // phy_specific_control: only bits 3:0 live here, rest read zero
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (take_wr && hit_ctrl && wb_sel_i[0]) begin
      nxt_ctrl.oe = wdata[PEVIS_CTRL_OE_POS];
      nxt_ctrl.gie = wdata[PEVIS_CTRL_GIE_POS];
      nxt_ctrl.tint = wdata[PEVIS_CTRL_TINT_POS];
      nxt_ctrl.pol = wdata[PEVIS_CTRL_POL_POS];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_ff.oe <= PEVIS_OE_RST;
      ctrl_ff.gie <= PEVIS_GIE_RST;
      ctrl_ff.tint <= PEVIS_TINT_RST;
      ctrl_ff.pol <= PEVIS_POL_RST;
    end else if (ce_i) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event enables; status and reserved bits of a write are dropped
  always_comb begin
    nxt_link_en = link_en_ff;
    if (take_wr && hit_link) begin
      nxt_link_en = (link_en_ff & ~wmask[PEVIS_LINK_EN_LSB +: PEVIS_LINK_N])
                  | (wdata[PEVIS_LINK_EN_LSB +: PEVIS_LINK_N]
                     & wmask[PEVIS_LINK_EN_LSB +: PEVIS_LINK_N]);
    end
  end

  always_comb begin
    nxt_line_en = line_en_ff;
    if (take_wr && hit_line) begin
      nxt_line_en = (line_en_ff & ~wmask[PEVIS_LINE_EN_LSB +: PEVIS_LINE_N])
                  | (wdata[PEVIS_LINE_EN_LSB +: PEVIS_LINE_N]
                     & wmask[PEVIS_LINE_EN_LSB +: PEVIS_LINE_N]);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      link_en_ff <= PEVIS_LINK_RST;
      line_en_ff <= PEVIS_LINE_RST;
    end else if (ce_i) begin
      link_en_ff <= nxt_link_en;
      line_en_ff <= nxt_line_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status latches
  // only the bits handed back by this read are cleared; anything that
  // arrives in the same cycle stays set for the next read
  assign link_clr = (take_rd && hit_link) ? link_sts : '0;
  assign line_clr = (take_rd && hit_line) ? line_sts : '0;

  // sources are counted once per pulse, no edge detect here
  pevis_sticky #(
    .W(PEVIS_LINK_N)
  ) u_link_sts (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .set_i(link_evt_i),
    .clr_i(link_clr),
    .q_o(link_sts)
  );

  pevis_sticky #(
    .W(PEVIS_LINE_N)
  ) u_line_sts (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .set_i(line_evt_i),
    .clr_i(line_clr),
    .q_o(line_sts)
  );

  //////////////////////////////////////////////////////////////////////////
  // read data; unmapped words answer with zero
  always_comb begin
    nxt_rdata = '0;
    if (hit_ctrl) begin
      nxt_rdata[PEVIS_CTRL_OE_POS] = ctrl_ff.oe;
      nxt_rdata[PEVIS_CTRL_GIE_POS] = ctrl_ff.gie;
      nxt_rdata[PEVIS_CTRL_TINT_POS] = ctrl_ff.tint;
      nxt_rdata[PEVIS_CTRL_POL_POS] = ctrl_ff.pol;
    end else if (hit_link) begin
      nxt_rdata[PEVIS_LINK_STS_LSB +: PEVIS_LINK_N] = link_sts;
      nxt_rdata[PEVIS_LINK_EN_LSB +: PEVIS_LINK_N] = link_en_ff;
    end else if (hit_line) begin
      nxt_rdata[PEVIS_LINE_STS_LSB +: PEVIS_LINE_N] = line_sts;
      nxt_rdata[PEVIS_LINE_EN_LSB +: PEVIS_LINE_N] = line_en_ff;
    end
  end

  // data is held past ack so a slow master still sees it
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_ff <= '0;
    end else if (ce_i && take_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt level
  assign event_irq = (|(link_sts & link_en_ff))
                   | (|(line_sts & line_en_ff));

  // test bit bypasses event gating but still needs the pin as output
  assign nxt_irq = ctrl_ff.oe
                 & ((ctrl_ff.gie & event_irq) | ctrl_ff.tint);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      irq_ff <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared pin: interrupt output or powerdown input
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_pin_ff <= PEVIS_POL_RST;
      oe_pin_ff <= PEVIS_OE_RST;
    end else if (ce_i) begin
      irq_pin_ff <= ctrl_ff.pol ? ~nxt_irq : nxt_irq;
      oe_pin_ff <= ctrl_ff.oe;
    end
  end

  // pin level is asynchronous to the register clock
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else if (ce_i) begin
      pin_meta_ff <= irq_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // powerdown is asked by a low pin, only while the pin is an input
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pd_ff <= 1'b0;
    end else if (ce_i) begin
      pd_ff <= ~ctrl_ff.oe & ~pin_sync_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;
  assign irq_o = irq_ff;
  assign irq_pin_o = irq_pin_ff;
  assign irq_pin_oe_o = oe_pin_ff;
  assign powerdown_o = pd_ff;

endmodule // pevis_top

/* File: sim/pevis_top_asserts.sv */
// Purpose: port-level checks of the event interrupt block
// Assumes: one clock domain, sync reset, ce_i high while judged
// Notes:   bound to pevis_top from the testbench file
`timescale 1ns/1ns
module pevis_top_chk
  import pevis_pkg::*;
(
  input wire logic ref_clk_i,                  // clock
  input wire logic reset_i,                    // sync reset
  input wire logic ce_i,                       // clock enable
  input wire logic wb_cyc_i,                   // cycle
  input wire logic wb_stb_i,                   // strobe
  input wire logic wb_we_i,                    // write
  input wire logic [PEVIS_ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [PEVIS_DAT_W-1:0] wb_dat_o, // read data
  input wire logic wb_ack_o,                   // ack
  input wire pevis_link_evt_t link_evt_i,      // link pulses
  input wire pevis_line_evt_t line_evt_i,      // line pulses
  input wire logic irq_pin_oe_o,               // pin enable
  input wire logic powerdown_o,                // powerdown level
  input wire logic irq_o                       // interrupt
);
  // a frozen clock enable holds everything, so nothing is judged then
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i || !ce_i);
  ////////////////////////////////////////////////////////////////////////
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_done;
    wb_ack_o && !wb_we_i;
  endsequence
  property p_answer;
    s_take |=> wb_ack_o;
  endproperty
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_hold;
    !(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) |=> $stable(wb_dat_o);
  endproperty
  property p_rsv_link;
    s_rd_done ##0 (wb_adr_i[7:2] == PEVIS_IDX_LINK) |->
      wb_dat_o[31:14] == 18'h00000 && wb_dat_o[7:6] == 2'h0;
  endproperty
  property p_rsv_line;
    s_rd_done ##0 (wb_adr_i[7:2] == PEVIS_IDX_LINE) |->
      wb_dat_o[31:15] == 17'h00000 && !wb_dat_o[7];
  endproperty
  property p_irq_oe;
    irq_o |-> irq_pin_oe_o;
  endproperty
  property p_pd;
    powerdown_o |-> !irq_pin_oe_o;
  endproperty
  // an interrupt appears only two edges after a pulse or after a write
  property p_rise;
    $rose(irq_o) |-> $past(wb_ack_o) || $past(|link_evt_i, 2) ||
      $past(|line_evt_i, 2);
  endproperty
  property p_fall;
    $fell(irq_o) |-> $past(wb_ack_o);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered in one cycle");
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  a_rsv_link: assert property (p_rsv_link)
    else $error("link register reserved bits set");
  a_rsv_line: assert property (p_rsv_line)
    else $error("line register reserved bits set");
  a_irq_oe: assert property (p_irq_oe)
    else $error("interrupt without output enable");
  a_pd: assert property (p_pd)
    else $error("powerdown while pin is an output");
  a_rise: assert property (p_rise)
    else $error("interrupt rose without cause");
  a_fall: assert property (p_fall)
    else $error("interrupt dropped without access");
endmodule // pevis_top_chk

/* File: sim/testbench.sv */
// Purpose: self-checking bench of pevis_top
// Assumes: ce_i low only in the freeze scenario, bench is the only master
// Notes:   pin wire resolves bench pull level against the block drive
`timescale 1ns/1ns
module testbench;
  import pevis_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, pin_o, pin_oe, pd, irq;
  logic pin_ext = 1'b1;
  wire logic pin;
  pevis_link_evt_t lev = 6'h00;
  pevis_line_evt_t nev = 7'h00;
  int fail_count = 0;
  int comparisons = 0;
  assign pin = pin_oe ? pin_o : pin_ext;
  always #2 ref_clk = ~ref_clk;
  pevis_top u_dut (.ref_clk_i(ref_clk), .reset_i(reset), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_evt_i(lev), .line_evt_i(nev), .irq_pin_i(pin),
    .irq_pin_o(pin_o), .irq_pin_oe_o(pin_oe), .powerdown_o(pd),
    .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1);
    // only the watchdog ends a hung wait; the latency is judged here
    chk("ack wait", 32'h00000002, n);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
    input string n);
    wb(1'b0, a, 16'h0000);
    chk(n, {16'h0000, e}, q);
  endtask
  task automatic bit1(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // one-cycle pulse, then two edges so flag and irq have landed
  task automatic pulse(input logic [5:0] l, input logic [6:0] m);
    lev <= l;
    nev <= m;
    @(posedge ref_clk);
    lev <= 6'h00;
    nev <= 7'h00;
    repeat (2) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h44, 16'h0008, "ctrl");
    rd(8'h48, 16'h0000, "link");
    rd(8'h4C, 16'h0000, "line");
    bit1("pin", 1'b1, pin_o);
    bit1("irq", 1'b0, irq);
  endtask
  task automatic t_regs();
    wb(1'b1, 8'h48, 16'hFFFF);
    rd(8'h48, 16'h003F, "link rw");
    wb(1'b1, 8'h4C, 16'hFFFF);
    rd(8'h4C, 16'h007F, "line rw");
    wb(1'b1, 8'h44, 16'hFFFF);
    rd(8'h44, 16'h000F, "ctrl rw");
    wb(1'b1, 8'h00, 16'hFFFF);
    rd(8'h00, 16'h0000, "unmapped");
    wb(1'b1, 8'h44, 16'h0008);
    wb(1'b1, 8'h48, 16'h0000);
    wb(1'b1, 8'h4C, 16'h0000);
  endtask
  task automatic t_latch();
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 7'h00);
      rd(8'h48, 16'h0100 << i, "link flag");
      rd(8'h48, 16'h0000, "link clr");
    end
    for (int j = 0; j < 7; j++) begin
      pulse(6'h00, 7'h01 << j);
      rd(8'h4C, 16'h0100 << j, "line flag");
      rd(8'h4C, 16'h0000, "line clr");
    end
    bit1("irq off", 1'b0, irq);
  endtask
  // a pulse seen while the clock enable is low must leave no flag
  task automatic t_freeze();
    ce <= 1'b0;
    pulse(6'h01, 7'h01);
    ce <= 1'b1;
    @(posedge ref_clk);
    rd(8'h48, 16'h0000, "frozen link");
    rd(8'h4C, 16'h0000, "frozen line");
  endtask
  task automatic t_irq();
    wb(1'b1, 8'h44, 16'h000B);
    wb(1'b1, 8'h48, 16'h0020);
    pulse(6'h10, 7'h00);
    bit1("irq masked", 1'b0, irq);
    rd(8'h48, 16'h1020, "speed");
    pulse(6'h20, 7'h00);
    bit1("irq on", 1'b1, irq);
    bit1("pin low", 1'b0, pin_o);
    bit1("pin oe", 1'b1, pin_oe);
    repeat (5) @(posedge ref_clk);
    bit1("irq level", 1'b1, irq);
    rd(8'h48, 16'h2020, "link");
    bit1("irq clr", 1'b0, irq);
    // flag already pending, a new event lands on the clearing edge
    pulse(6'h20, 7'h00);
    fork
      wb(1'b0, 8'h48, 16'h0000);
      pulse(6'h20, 7'h00);
    join
    chk("race rd", 32'h00002020, q);
    rd(8'h48, 16'h2020, "race kept");
    pulse(6'h20, 7'h00);
    wb(1'b1, 8'h44, 16'h0009);
    bit1("gie off", 1'b0, irq);
    wb(1'b1, 8'h44, 16'h000D);
    bit1("test irq", 1'b1, irq);
    wb(1'b1, 8'h44, 16'h0005);
    bit1("pin high", 1'b1, pin_o);
    wb(1'b1, 8'h44, 16'h0004);
    bit1("oe off", 1'b0, irq);
    bit1("pin in", 1'b0, pin_oe);
    pin_ext <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bit1("pd on", 1'b1, pd);
    pin_ext <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bit1("pd off", 1'b0, pd);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_regs();
    t_latch();
    t_freeze();
    t_irq();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
endmodule // testbench
bind pevis_top pevis_top_chk u_chk (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_evt_i(link_evt_i),
  .line_evt_i(line_evt_i), .irq_pin_oe_o(irq_pin_oe_o),
  .powerdown_o(powerdown_o), .irq_o(irq_o));
